// ===== hdl/pda_autoresp.sv
// auto-response sequencer with abort cause recording and tx power timing, apb slave
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pda_autoresp (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // mac side events
    input wire logic i_ar_request,
    input wire logic i_rx_start,
    input wire logic i_line_busy,
    input wire logic i_tx_done,
    // analog transmitter control
    output logic o_tx_power_en,
    output logic o_tx_send,
    // status and interrupt event
    output logic o_ar_busy,
    output logic o_auto_reply_abort_irq
);
    import pda_pkg::*;

    // register state
    logic [7:0] auto_reply_abort_cause;
    logic [7:0] next_auto_reply_abort_cause;
    logic [5:0] turnaround_us_count;
    logic [5:0] next_turnaround_us_count;
    logic [7:0] tx_warmup_count;
    logic [7:0] next_tx_warmup_count;
    logic [7:0] tx_cooldown_count;
    logic [7:0] next_tx_cooldown_count;
    logic auto_reply_abort_irq;
    logic next_auto_reply_abort_irq;
    logic [31:0] prdata;
    logic [31:0] next_prdata;
    logic pslverr;
    logic next_pslverr;

    // sequencer state
    pda_state_e state;
    pda_state_e next_state;
    logic [TICK_W-1:0] tick_cnt;
    logic [TICK_W-1:0] next_tick_cnt;

    // combinational terms
    logic setup_ph;
    logic access_ph;
    logic addr_hit;
    logic wr_en;
    logic abort_cmd;
    logic us_tick;
    logic ev_rx;
    logic ev_busy;
    logic ev_abort;
    logic timer_load;
    logic [TIMER_W-1:0] timer_val;
    logic timer_zero;
    logic ta_load;
    logic ta_zero;
    logic [TIMER_W-1:0] warm_val;
    logic [TIMER_W-1:0] cool_val;
    logic [7:0] ev_bits;
    logic [7:0] clr_bits;
    logic [7:0] kept_bits;

    // apb phases; no wait states, so every access ends at its first edge
    assign setup_ph = i_psel && !i_penable;
    assign access_ph = i_psel && i_penable;
    assign addr_hit = (i_paddr[1:0] == 2'h0) &&
        ((i_paddr == ADDR_TURNAROUND) || (i_paddr == ADDR_ABORT_CAUSE) ||
         (i_paddr == ADDR_WARMUP) || (i_paddr == ADDR_COOLDOWN) ||
         (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS));
    assign wr_en = access_ph && i_pwrite && i_pstrb[0] && addr_hit;
    assign abort_cmd = wr_en && (i_paddr == ADDR_CTRL) && i_pwdata[CTRL_ABORT_BIT];

    // power windows: count times 8 plus the fixed clocks, minus one for the load cycle
    assign warm_val = {tx_warmup_count, 3'h0} + WARMUP_EXTRA - TIMER_W'(1);
    assign cool_val = {tx_cooldown_count, 3'h0} + COOLDOWN_EXTRA - TIMER_W'(1);

    // free-running microsecond tick; turnaround may run up to one tick short
    assign us_tick = (tick_cnt == TICK_LAST);
    assign next_tick_cnt = us_tick ? '0 : tick_cnt + TICK_W'(1);

    // shared power timer for warmup and cooldown
    pda_down_counter #(
        .WIDTH(TIMER_W)
    ) u_power_timer (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_load(timer_load),
        .i_load_val(timer_val),
        .i_dec(state == ST_WARM || state == ST_COOL),
        .o_count(),
        .o_zero(timer_zero)
    );

    // turnaround counter counts microsecond ticks
    pda_down_counter #(
        .WIDTH(6)
    ) u_turn_timer (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_load(ta_load),
        .i_load_val(turnaround_us_count),
        .i_dec(us_tick),
        .o_count(),
        .o_zero(ta_zero)
    );

    // sequencer: turnaround, warmup, send, cooldown
    always_comb
    begin
        next_state = state;
        ev_rx = 1'b0;
        ev_busy = 1'b0;
        ev_abort = 1'b0;
        timer_load = 1'b0;
        timer_val = '0;
        ta_load = 1'b0;
        unique case (state)
            ST_IDLE:
            begin
                if (i_ar_request)
                begin
                    next_state = ST_TURN;
                    ta_load = 1'b1;
                end
            end
            ST_TURN:
            begin
                // abort and reception may coincide, both get recorded
                if (abort_cmd || i_rx_start)
                begin
                    ev_abort = abort_cmd;
                    ev_rx = i_rx_start;
                    next_state = ST_IDLE;
                end
                else if (ta_zero)
                begin
                    if (i_line_busy)
                    begin
                        ev_busy = 1'b1;
                        next_state = ST_IDLE;
                    end
                    else
                    begin
                        next_state = ST_WARM;
                        timer_load = 1'b1;
                        timer_val = warm_val;
                    end
                end
            end
            ST_WARM:
            begin
                if (abort_cmd)
                begin
                    ev_abort = 1'b1;
                    next_state = ST_COOL;
                    timer_load = 1'b1;
                    timer_val = cool_val;
                end
                else if (timer_zero)
                begin
                    next_state = ST_SEND;
                end
            end
            ST_SEND:
            begin
                // an aborted send still cools down so the analog is never cut mid-drive
                if (abort_cmd || i_tx_done)
                begin
                    ev_abort = abort_cmd;
                    next_state = ST_COOL;
                    timer_load = 1'b1;
                    timer_val = cool_val;
                end
            end
            ST_COOL:
            begin
                if (timer_zero)
                begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // abort cause field: sticky, write-one-to-clear, an event is recorded only if the field is empty after any clear
    always_comb
    begin
        ev_bits = 8'h00;
        ev_bits[CAUSE_RX_BIT] = ev_rx;
        ev_bits[CAUSE_BUSY_BIT] = ev_busy;
        ev_bits[CAUSE_SWABORT_BIT] = ev_abort;
        clr_bits = 8'h00;
        if (wr_en && (i_paddr == ADDR_ABORT_CAUSE))
        begin
            clr_bits = i_pwdata[7:0] & CAUSE_MASK;
        end
        kept_bits = auto_reply_abort_cause & ~clr_bits;
        if (kept_bits == 8'h00)
        begin
            next_auto_reply_abort_cause = ev_bits & CAUSE_MASK;
            next_auto_reply_abort_irq = (ev_bits != 8'h00);
        end
        else
        begin
            next_auto_reply_abort_cause = kept_bits;
            next_auto_reply_abort_irq = 1'b0;
        end
    end

    // programmable counts written over apb
    always_comb
    begin
        next_turnaround_us_count = turnaround_us_count;
        next_tx_warmup_count = tx_warmup_count;
        next_tx_cooldown_count = tx_cooldown_count;
        if (wr_en && (i_paddr == ADDR_TURNAROUND))
        begin
            next_turnaround_us_count = i_pwdata[5:0];
        end
        if (wr_en && (i_paddr == ADDR_WARMUP))
        begin
            next_tx_warmup_count = i_pwdata[7:0];
        end
        if (wr_en && (i_paddr == ADDR_COOLDOWN))
        begin
            next_tx_cooldown_count = i_pwdata[7:0];
        end
    end

    // read data and error captured in the setup phase, held through access
    always_comb
    begin
        next_prdata = prdata;
        next_pslverr = access_ph ? pslverr : 1'b0;
        if (setup_ph)
        begin
            next_pslverr = !addr_hit;
            next_prdata = 32'h0000_0000;
            if (!i_pwrite)
            begin
                unique case (i_paddr)
                    ADDR_TURNAROUND: next_prdata[5:0] = turnaround_us_count;
                    ADDR_ABORT_CAUSE: next_prdata[7:0] = auto_reply_abort_cause;
                    ADDR_WARMUP: next_prdata[7:0] = tx_warmup_count;
                    ADDR_COOLDOWN: next_prdata[7:0] = tx_cooldown_count;
                    ADDR_STATUS:
                    begin
                        next_prdata[STATUS_BUSY_BIT] = (state != ST_IDLE);
                        next_prdata[STATUS_STATE_LSB +: 5] = state;
                    end
                    default: next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // all registers
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state <= ST_IDLE;
            tick_cnt <= '0;
            auto_reply_abort_cause <= CAUSE_RST;
            auto_reply_abort_irq <= 1'b0;
            turnaround_us_count <= TURNAROUND_RST;
            tx_warmup_count <= WARMUP_RST;
            tx_cooldown_count <= COOLDOWN_RST;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            auto_reply_abort_cause <= next_auto_reply_abort_cause;
            auto_reply_abort_irq <= next_auto_reply_abort_irq;
            turnaround_us_count <= next_turnaround_us_count;
            tx_warmup_count <= next_tx_warmup_count;
            tx_cooldown_count <= next_tx_cooldown_count;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // outputs from flops or decoded from the state flops; pready tied high
    assign o_tx_power_en = (state == ST_WARM) || (state == ST_SEND) || (state == ST_COOL);
    assign o_tx_send = (state == ST_SEND);
    assign o_ar_busy = (state != ST_IDLE);
    assign o_auto_reply_abort_irq = auto_reply_abort_irq;
    assign o_prdata = prdata;
    assign o_pready = 1'b1;
    assign o_pslverr = pslverr;
endmodule : pda_autoresp
`default_nettype wire

// ===== inc/pda_pkg.sv
// constants, register map and state codes of the auto-response abort and tx power timing block
`default_nettype none
package pda_pkg;

    // register indices as printed; the byte address is four times the index
    localparam logic [15:0] IDX_TURNAROUND = 16'h1A08;
    localparam logic [15:0] IDX_ABORT_CAUSE = 16'h1A0A;
    localparam logic [15:0] IDX_WARMUP = 16'h1A0B;
    localparam logic [15:0] IDX_COOLDOWN = 16'h1A0C;
    localparam logic [15:0] IDX_CTRL = 16'h1A0D;
    localparam logic [15:0] IDX_STATUS = 16'h1A0E;
    localparam logic [15:0] ADDR_TURNAROUND = IDX_TURNAROUND << 2;
    localparam logic [15:0] ADDR_ABORT_CAUSE = IDX_ABORT_CAUSE << 2;
    localparam logic [15:0] ADDR_WARMUP = IDX_WARMUP << 2;
    localparam logic [15:0] ADDR_COOLDOWN = IDX_COOLDOWN << 2;
    localparam logic [15:0] ADDR_CTRL = IDX_CTRL << 2;
    localparam logic [15:0] ADDR_STATUS = IDX_STATUS << 2;

    // abort cause field layout
    localparam int CAUSE_RX_BIT = 6;
    localparam int CAUSE_BUSY_BIT = 3;
    localparam int CAUSE_SWABORT_BIT = 1;
    localparam logic [7:0] CAUSE_MASK = 8'h4A;
    localparam logic [7:0] CAUSE_RST = 8'h00;

    // control and status field layout
    localparam int CTRL_ABORT_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_STATE_LSB = 1;

    // reset values of the programmable counts
    localparam logic [5:0] TURNAROUND_RST = 6'h15;
    localparam logic [7:0] WARMUP_RST = 8'h00;
    localparam logic [7:0] COOLDOWN_RST = 8'h00;

    // power timing: count times 8 plus a fixed number of clocks
    localparam int TIMER_W = 11;
    localparam logic [TIMER_W-1:0] WARMUP_EXTRA = 11'h005;
    localparam logic [TIMER_W-1:0] COOLDOWN_EXTRA = 11'h002;

    // microsecond tick derived from the system clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 6;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(US_CYCLES - 1);

    // auto-response sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_TURN = 5'h02,
        ST_WARM = 5'h04,
        ST_SEND = 5'h08,
        ST_COOL = 5'h10
    } pda_state_e;

endpackage : pda_pkg
`default_nettype wire

// ===== hdl/pda_down_counter.sv
// loadable down counter that stops at zero
`timescale 1ns/1ps
`default_nettype none
module pda_down_counter #(
    parameter int WIDTH = 11
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // control
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_load_val,
    input wire logic i_dec,
    // status
    output logic [WIDTH-1:0] o_count,
    output logic o_zero
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // load wins over decrement; saturate at zero
    always_comb
    begin
        next_count = count;
        if (i_load)
        begin
            next_count = i_load_val;
        end
        else if (i_dec && (count != '0))
        begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end

    assign o_count = count;
    assign o_zero = (count == '0);
endmodule : pda_down_counter
`default_nettype wire

// ===== tb/pda_autoresp_chk.sv
// port assertions of the auto-response block
`timescale 1ns/1ps
`default_nettype none
module pda_autoresp_chk (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // apb and events
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic i_ar_request,
    input wire logic [31:0] o_prdata,
    // sequencer outputs
    input wire logic o_tx_power_en,
    input wire logic o_tx_send,
    input wire logic o_ar_busy,
    input wire logic o_auto_reply_abort_irq
);
    import pda_pkg::*;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);
    // irq is a single-cycle event tied to an active sequence
    AST_IRQ_PULSE: assert property (o_auto_reply_abort_irq |=> !o_auto_reply_abort_irq)
        else $error("irq high two cycles");
    AST_IRQ_FROM_BUSY: assert property (o_auto_reply_abort_irq |-> $past(o_ar_busy))
        else $error("irq without a running response");
    // power sequencing of the analog side and request take-up
    AST_SEND_POWERED: assert property (o_tx_send |-> o_tx_power_en)
        else $error("send without power");
    AST_WARMUP_MIN: assert property ($rose(o_tx_power_en) |-> !o_tx_send [*5])
        else $error("warmup shorter than five clocks");
    AST_COOLDOWN_MIN: assert property ($fell(o_tx_send) |-> o_tx_power_en [*2])
        else $error("cooldown shorter than two clocks");
    AST_POWER_BUSY: assert property (o_tx_power_en |-> o_ar_busy)
        else $error("power on while idle");
    AST_START: assert property (!o_ar_busy && i_ar_request |=> o_ar_busy)
        else $error("request not taken");
    // reserved cause bits never read back set
    AST_CAUSE_RSVD: assert property (i_psel && i_penable && !i_pwrite && i_paddr == ADDR_ABORT_CAUSE
        |-> (o_prdata & ~{24'h0, CAUSE_MASK}) == 32'h0) else $error("reserved cause bit set");
endmodule : pda_autoresp_chk
`default_nettype wire

// ===== tb/pda_tx_analog.sv
// behavioural analog transmitter: answers a send with a done pulse
`timescale 1ns/1ps
`default_nettype none
module pda_tx_analog (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // control from the block
    input wire logic i_power_en,
    input wire logic i_send,
    input wire logic [15:0] i_delay,
    // answers
    output logic o_done,
    output logic o_fault
);
    logic [15:0] cnt;
    // done after i_delay plus one send cycles; a send while unpowered is latched as a fault
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt <= 16'h0;
            o_done <= 1'b0;
            o_fault <= 1'b0;
        end
        else
        begin
            o_done <= i_send && cnt == i_delay;
            cnt <= i_send ? cnt + 16'h1 : 16'h0;
            o_fault <= o_fault | (i_send & ~i_power_en);
        end
    end
endmodule : pda_tx_analog
`default_nettype wire

// ===== tb/pda_autoresp_test.sv
// self-checking bench of the auto-response block
`timescale 1ns/1ps
`default_nettype none
module pda_autoresp_test;
    import pda_pkg::*;
    logic i_mclk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [15:0] i_paddr = 16'h0, dly = 16'h8;
    logic [31:0] i_pwdata = 32'h0, seed = 32'h19, r;
    logic [3:0] i_pstrb = 4'hF;
    logic i_ar_request = 1'b0, i_rx_start = 1'b0, i_line_busy = 1'b0, i_tx_done, fault;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_tx_power_en, o_tx_send, o_ar_busy, o_auto_reply_abort_irq;
    logic [32:0] expq[$];
    logic [7:0] wu, cd;
    int err_total = 0, checks_done = 0, irq_n = 0, w, c;

    always #10 i_mclk = ~i_mclk;

    pda_autoresp i_dut (.i_mclk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
        .o_prdata, .o_pready, .o_pslverr, .i_ar_request, .i_rx_start, .i_line_busy, .i_tx_done,
        .o_tx_power_en, .o_tx_send, .o_ar_busy, .o_auto_reply_abort_irq);
    pda_tx_analog i_far (.i_mclk, .i_nrst, .i_power_en(o_tx_power_en), .i_send(o_tx_send),
        .i_delay(dly), .o_done(i_tx_done), .o_fault(fault));

    task tally_and_finish();
        if (err_total == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task chk(input string n, input logic [32:0] e, input logic [32:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // apb master: setup, then access held until pready
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge i_mclk);
        i_penable <= 1'b1;
        @(posedge i_mclk);
        while (o_pready !== 1'b1) @(posedge i_mclk);
        {i_psel, i_penable} <= 2'b00;
    endtask : apb

    task rd(input logic [15:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // oldest expectation against each completed read; irq events counted
    always @(posedge i_mclk)
    begin
        if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite && expq.size() > 0)
            chk("apb read", expq.pop_front(), {o_pslverr, o_prdata});
        if (o_auto_reply_abort_irq === 1'b1) irq_n++;
    end

    // one response; counts powered send-free warm and cool cycles at the falling edge
    // ab: 0 no abort, 1 abort write issued on first send cycle, 2 abort write issued on first warmup cycle
    task run_ar(input logic [1:0] ab);
        bit seen;
        seen = 0;
        w = 0;
        c = 0;
        @(posedge i_mclk);
        i_ar_request <= 1'b1;
        @(posedge i_mclk);
        i_ar_request <= 1'b0;
        repeat (5000)
        begin
            @(negedge i_mclk);
            if (o_tx_send === 1'b1)
            begin
                if (ab == 2'h1 && !seen) fork apb(1'b1, ADDR_CTRL, 32'h1); join_none
                seen = 1;
            end
            else if (o_tx_power_en === 1'b1)
            begin
                if (ab == 2'h2 && w == 0) fork apb(1'b1, ADDR_CTRL, 32'h1); join_none
                if (seen) c++;
                else w++;
            end
            else if (seen || o_ar_busy !== 1'b1) break;
        end
        repeat (4) @(posedge i_mclk);
    endtask : run_ar

    // request, then abort write and rx start landing on the same edge during turnaround
    task turn_hit(input bit ab, input bit rx);
        @(posedge i_mclk);
        i_ar_request <= 1'b1;
        @(posedge i_mclk);
        i_ar_request <= 1'b0;
        fork
            apb(1'b1, ADDR_CTRL, {31'h0, ab});
            begin
                repeat (2) @(posedge i_mclk);
                i_rx_start <= rx;
                @(posedge i_mclk);
                i_rx_start <= 1'b0;
            end
        join
        while (o_ar_busy === 1'b1) @(posedge i_mclk);
    endtask : turn_hit

    initial
    begin
        repeat (5) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rd(ADDR_WARMUP, 33'h0);
        rd(ADDR_COOLDOWN, 33'h0);
        rd(ADDR_TURNAROUND, {27'h0, TURNAROUND_RST});
        rd(ADDR_ABORT_CAUSE, 33'h0);
        rd(16'h6831, {1'b1, 32'h0});
        apb(1'b1, ADDR_TURNAROUND, 32'h1);
        // zero counts with a slow far side, then random counts with a prompt one
        for (int k = 0; k < 2; k++)
        begin
            r = xs();
            // random counts kept at or above 5 us warmup and 1 us cooldown at 50 MHz
            wu = k ? (r[7:0] | 8'h20) : 8'h00;
            cd = k ? (r[15:8] | 8'h08) : 8'h00;
            apb(1'b1, ADDR_WARMUP, {24'h0, wu});
            apb(1'b1, ADDR_COOLDOWN, {24'h0, cd});
            rd(ADDR_COOLDOWN, {25'h0, cd});
            dly <= k ? 16'h3 : 16'h28;
            run_ar(2'h0);
            chk("warmup cycles", wu * 8 + 5, w);
            chk("cooldown cycles", cd * 8 + 2, c);
        end
        i_pstrb <= 4'hE;
        apb(1'b1, ADDR_WARMUP, 32'h0);
        i_pstrb <= 4'hF;
        rd(ADDR_WARMUP, {25'h0, wu});
        // line busy when turnaround ends: no power, cause bit 3
        i_line_busy <= 1'b1;
        run_ar(2'h0);
        i_line_busy <= 1'b0;
        chk("busy power cycles", 33'h0, w + c);
        rd(ADDR_ABORT_CAUSE, 33'h08);
        chk("irq count", 33'h1, irq_n);
        // sticky field drops a second cause
        apb(1'b1, ADDR_TURNAROUND, 32'h3);
        turn_hit(1'b0, 1'b1);
        rd(ADDR_ABORT_CAUSE, 33'h08);
        apb(1'b1, ADDR_ABORT_CAUSE, 32'h0);
        rd(ADDR_ABORT_CAUSE, 33'h08);
        apb(1'b1, ADDR_ABORT_CAUSE, 32'hFF);
        rd(ADDR_ABORT_CAUSE, 33'h0);
        turn_hit(1'b0, 1'b1);
        rd(ADDR_ABORT_CAUSE, 33'h40);
        apb(1'b1, ADDR_ABORT_CAUSE, 32'h40);
        turn_hit(1'b1, 1'b1);
        rd(ADDR_ABORT_CAUSE, 33'h42);
        apb(1'b1, ADDR_ABORT_CAUSE, 32'h42);
        // abort while sending still cools down fully
        apb(1'b1, ADDR_TURNAROUND, 32'h1);
        dly <= 16'h12C;
        run_ar(2'h1);
        chk("abort cooldown", cd * 8 + 2, c);
        rd(ADDR_ABORT_CAUSE, 33'h02);
        chk("irq count", 33'h4, irq_n);
        // abort lands 3 warmup cycles in (two-edge apb write), then full cooldown, no send
        apb(1'b1, ADDR_ABORT_CAUSE, 32'h02);
        run_ar(2'h2);
        chk("warm abort power cycles", cd * 8 + 5, w);
        chk("warm abort send cycles", 33'h0, c);
        rd(ADDR_ABORT_CAUSE, 33'h02);
        chk("irq count", 33'h5, irq_n);
        chk("unpowered send", 33'h0, {32'h0, fault});
        tally_and_finish();
    end

    // hang guard, well past the longest expected run
    initial
    begin
        #1500000;
        err_total++;
        tally_and_finish();
    end
endmodule : pda_autoresp_test

bind pda_autoresp pda_autoresp_chk u_chk (.i_mclk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_ar_request, .o_prdata, .o_tx_power_en, .o_tx_send, .o_ar_busy, .o_auto_reply_abort_irq);
`default_nettype wire
